// >>> arinc_pkg.sv
// Shared constants, types and helpers of the serial word codec.
package arinc_pkg;

   // ****************************************************************
   // Clock, rates and timing
   // ****************************************************************
   localparam int CLK_HZ = 20_000_000;
   localparam int RATE_LO_BPS = 12_500;
   localparam int RATE_MID_BPS = 50_000;
   localparam int RATE_HI_BPS = 100_000;
   localparam int CNT_W = 11;
   localparam int IDLE_W = 13;
   localparam logic [CNT_W-1:0] CYC_LO = CNT_W'(CLK_HZ / RATE_LO_BPS);
   localparam logic [CNT_W-1:0] CYC_MID = CNT_W'(CLK_HZ / RATE_MID_BPS);
   localparam logic [CNT_W-1:0] CYC_HI = CNT_W'(CLK_HZ / RATE_HI_BPS);
   localparam logic [1:0] RATE_SEL_LO = 2'h0;
   localparam logic [1:0] RATE_SEL_HI = 2'h1;
   localparam logic [1:0] RATE_SEL_MID = 2'h2;
   localparam int TX_GAP_BITS = 4;
   localparam int RX_GAP_BITS = 2;

   // ****************************************************************
   // Word layout
   // ****************************************************************
   localparam int WORD_BITS = 32;
   localparam int MAX_CHAN = 16;
   localparam int PARITY_POS = 31;
   localparam int SIGN_STATUS_LSB = 29;
   localparam int PAYLOAD_LSB = 10;
   localparam int SOURCE_DEST_LSB = 8;
   localparam int LABEL_BITS = 8;
   localparam int LABEL_DEPTH = 256;
   localparam logic LABEL_RESET = 1'b1;

   typedef enum logic [1:0] {TX_IDLE, TX_SEND, TX_GAP} tx_state_e;

   // Rate code 3 is unused and falls back to the slow rate.
   function automatic logic [CNT_W-1:0] bit_cycles(input logic [1:0] sel);
      logic [CNT_W-1:0] c;
      c = CYC_LO;
      unique case (sel)
         RATE_SEL_HI: c = CYC_HI;
         RATE_SEL_MID: c = CYC_MID;
         default: c = CYC_LO;
      endcase
      return c;
   endfunction : bit_cycles

   // Maps serial slot n to its word bit: label bit 8 down to 1, then 9 up.
   function automatic logic [4:0] wire_index(input logic [4:0] n);
      return (n < 5'h08) ? 5'h07 - n : n;
   endfunction : wire_index

endpackage : arinc_pkg

// >>> label_mem.sv
// Per-channel label acceptance memory with registered read.
`timescale 1ns/1ps
`default_nettype none
module label_mem #(
   parameter int DEPTH = 256,
   parameter int AW = 8
) (
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic wr_en,
   input wire logic [AW-1:0] wr_addr,
   input wire logic wr_data,
   input wire logic [AW-1:0] rd_addr,
   output logic rd_data
);
   logic mem_q [DEPTH];

   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
      begin
         for (int i = 0; i < DEPTH; i++)
            mem_q[i] <= arinc_pkg::LABEL_RESET;
         rd_data <= 1'b0;
      end
      else
      begin
         if (wr_en)
            mem_q[wr_addr] <= wr_data;
         rd_data <= mem_q[rd_addr];
      end
   end
endmodule : label_mem
`default_nettype wire

// >>> word_buf.sv
// Small valid/ready FIFO that decouples received words from the user.
`timescale 1ns/1ps
`default_nettype none
module word_buf #(
   parameter int WIDTH = 33,
   parameter int DEPTH = 2
) (
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int PW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [PW-1:0] wp_q, wp_d, rp_q, rp_d;
   logic [PW:0] cnt_q, cnt_d;
   logic push, pop;

   assign in_ready = cnt_q != (PW+1)'(DEPTH);
   assign out_valid = cnt_q != '0;
   assign out_data = mem_q[rp_q];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   always_comb
   begin
      wp_d = wp_q;
      rp_d = rp_q;
      if (push)
         wp_d = (wp_q == PW'(DEPTH-1)) ? '0 : wp_q + 1'b1;
      if (pop)
         rp_d = (rp_q == PW'(DEPTH-1)) ? '0 : rp_q + 1'b1;
      cnt_d = cnt_q + (PW+1)'(push) - (PW+1)'(pop);
   end

   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
      begin
         wp_q <= '0;
         rp_q <= '0;
         cnt_q <= '0;
      end
      else
      begin
         wp_q <= wp_d;
         rp_q <= rp_d;
         cnt_q <= cnt_d;
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (push)
         mem_q[wp_q] <= in_data;
   end

   property p_full_stall;
      @(posedge clk_sys) disable iff (!resetn)
      (cnt_q == (PW+1)'(DEPTH)) |-> !in_ready;
   endproperty
   a_full_stall: assert property (p_full_stall)
      else $error("buffer accepts while full");

   property p_hold_head;
      @(posedge clk_sys) disable iff (!resetn)
      (out_valid && !out_ready) |=> out_valid && $stable(out_data);
   endproperty
   a_hold_head: assert property (p_hold_head)
      else $error("buffer head changed while stalled");
endmodule : word_buf
`default_nettype wire

// >>> arinc_word_codec.sv
// Serial word codec: transmit serialisers and receive deserialisers.
`timescale 1ns/1ps
`default_nettype none
module arinc_word_codec #(
   parameter int N_TX = 1,
   parameter int N_RX = 1
) (
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic [1:0] tx_rate [N_TX],
   input wire logic [30:0] tx_word [N_TX],
   input wire logic tx_valid [N_TX],
   output logic tx_ready [N_TX],
   output logic tx_hi [N_TX],
   output logic tx_lo [N_TX],
   input wire logic [1:0] rx_rate [N_RX],
   input wire logic rx_hi [N_RX],
   input wire logic rx_lo [N_RX],
   input wire logic lbl_wr_en,
   input wire logic [3:0] lbl_wr_chan,
   input wire logic [7:0] lbl_wr_label,
   input wire logic lbl_wr_accept,
   output logic [31:0] rx_word [N_RX],
   output logic rx_parity_err [N_RX],
   output logic rx_valid [N_RX],
   input wire logic rx_ready [N_RX],
   output logic rx_overrun [N_RX]
);
   default clocking @(posedge clk_sys);
   endclocking
   default disable iff (!resetn);

   localparam int W = arinc_pkg::WORD_BITS;
   localparam int CW = arinc_pkg::CNT_W;
   localparam int IW = arinc_pkg::IDLE_W;

   // ****************************************************************
   // Parameter checks, asserted at each clock edge
   // ****************************************************************
   property p_chan_range;
      N_TX >= 1 && N_TX <= arinc_pkg::MAX_CHAN &&
      N_RX >= 1 && N_RX <= arinc_pkg::MAX_CHAN;
   endproperty
   a_chan_range: assert property (p_chan_range)
      else $error("channel count out of range");

   // ****************************************************************
   // Transmit channels
   // ****************************************************************
   // Each channel drives its output pair and its tx_ready only, never a receive pin.
   for (genvar g = 0; g < N_TX; g++)
   begin : g_tx
      arinc_pkg::tx_state_e state_q, state_d;
      logic [W-1:0] frame_q, frame_d;
      logic [CW-1:0] per_q, per_d, tick_q, tick_d;
      logic [4:0] bit_q, bit_d;
      logic hi_q, hi_d, lo_q, lo_d;
      logic last, lvl;

      assign last = tick_q == per_q - 1'b1;
      assign lvl = frame_q[arinc_pkg::wire_index(bit_q)];
      assign tx_ready[g] = state_q == arinc_pkg::TX_IDLE;
      assign tx_hi[g] = hi_q;
      assign tx_lo[g] = lo_q;

      always_comb
      begin
         state_d = state_q;
         frame_d = frame_q;
         per_d = per_q;
         tick_d = last ? '0 : tick_q + 1'b1;
         bit_d = bit_q;
         // Return-to-zero: drive the first half bit, Null the second.
         hi_d = 1'b0;
         lo_d = 1'b0;
         unique case (state_q)
            arinc_pkg::TX_IDLE:
            begin
               tick_d = '0;
               bit_d = '0;
               if (tx_valid[g])
               begin
                  // Fields pass as given; parity makes the word odd.
                  frame_d = {~^tx_word[g], tx_word[g]};
                  per_d = arinc_pkg::bit_cycles(tx_rate[g]);
                  state_d = arinc_pkg::TX_SEND;
               end
            end
            arinc_pkg::TX_SEND:
            begin
               hi_d = (tick_q < (per_q >> 1)) && lvl;
               lo_d = (tick_q < (per_q >> 1)) && !lvl;
               if (last)
               begin
                  bit_d = bit_q + 1'b1;
                  if (bit_q == 5'(W-1))
                  begin
                     bit_d = '0;
                     state_d = arinc_pkg::TX_GAP;
                  end
               end
            end
            arinc_pkg::TX_GAP:
            begin
               if (last)
               begin
                  bit_d = bit_q + 1'b1;
                  if (bit_q == 5'(arinc_pkg::TX_GAP_BITS-1))
                     state_d = arinc_pkg::TX_IDLE;
               end
            end
            default: state_d = arinc_pkg::TX_IDLE;
         endcase
      end

      always_ff @(posedge clk_sys or negedge resetn)
      begin
         if (!resetn)
         begin
            state_q <= arinc_pkg::TX_IDLE;
            frame_q <= '0;
            per_q <= arinc_pkg::CYC_LO;
            tick_q <= '0;
            bit_q <= '0;
            hi_q <= 1'b0;
            lo_q <= 1'b0;
         end
         else
         begin
            state_q <= state_d;
            frame_q <= frame_d;
            per_q <= per_d;
            tick_q <= tick_d;
            bit_q <= bit_d;
            hi_q <= hi_d;
            lo_q <= lo_d;
         end
      end

      property p_tx_fields;
         (tx_valid[g] && tx_ready[g]) |=>
            frame_q[W-2:0] == $past(tx_word[g]) && (^frame_q);
      endproperty
      a_tx_fields: assert property (p_tx_fields)
         else $error("frame fields or parity wrong");

      property p_tx_first;
         (state_q == arinc_pkg::TX_SEND && bit_q == '0 && tick_q == '0)
            |=> tx_hi[g] == frame_q[7] && tx_lo[g] == !frame_q[7];
      endproperty
      a_tx_first: assert property (p_tx_first)
         else $error("first bit on line is not label bit 8");

      property p_tx_len;
         (state_q == arinc_pkg::TX_SEND && state_d == arinc_pkg::TX_GAP)
            |-> bit_q == 5'(W-1) && last;
      endproperty
      a_tx_len: assert property (p_tx_len)
         else $error("word left early or late");

      property p_tx_null;
         (state_q != arinc_pkg::TX_SEND) |=> !tx_hi[g] && !tx_lo[g];
      endproperty
      a_tx_null: assert property (p_tx_null)
         else $error("line driven outside a word");

      property p_tx_gap;
         (state_q == arinc_pkg::TX_SEND && state_d == arinc_pkg::TX_GAP)
            |=> (!tx_ready[g]) [*8];
      endproperty
      a_tx_gap: assert property (p_tx_gap)
         else $error("next word accepted without a gap");

      property p_tx_excl;
         !(tx_hi[g] && tx_lo[g]);
      endproperty
      a_tx_excl: assert property (p_tx_excl)
         else $error("both line levels driven");
   end

   // ****************************************************************
   // Receive channels
   // ****************************************************************
   for (genvar g = 0; g < N_RX; g++)
   begin : g_rx
      logic [W-1:0] sh_q, sh_d, word_q, word_d, hold_q, hold_d;
      logic [5:0] cnt_q, cnt_d;
      logic [IW-1:0] idle_q, idle_d, gap_lim;
      logic prev_q, chk1_q, chk1_d, chk2_q, hold_v_q, hold_v_d;
      logic ovr_q, ovr_d, act, start, accept, in_ready, we;
      logic [W:0] out_data;

      // A gap of two bit times is well short of the sender's four.
      assign gap_lim = IW'(arinc_pkg::bit_cycles(rx_rate[g]) *
                           arinc_pkg::RX_GAP_BITS);
      assign act = rx_hi[g] || rx_lo[g];
      // Both levels at once is a line fault and starts no bit.
      assign start = act && !prev_q && !(rx_hi[g] && rx_lo[g]);
      assign we = lbl_wr_en && lbl_wr_chan == 4'(g);

      always_comb
      begin
         sh_d = sh_q;
         cnt_d = cnt_q;
         word_d = word_q;
         chk1_d = 1'b0;
         idle_d = act ? '0 : ((idle_q == gap_lim) ? idle_q : idle_q + 1'b1);
         if (start)
         begin
            sh_d[arinc_pkg::wire_index(cnt_q[4:0])] = rx_hi[g];
            cnt_d = cnt_q + 1'b1;
            if (cnt_q == 6'(W-1))
            begin
               cnt_d = '0;
               word_d = sh_d;
               chk1_d = 1'b1;
            end
         end
         else if (idle_q == gap_lim)
            cnt_d = '0;
         hold_d = hold_q;
         hold_v_d = hold_v_q && !in_ready;
         ovr_d = 1'b0;
         // A newer word replaces one the buffer could not take.
         if (chk2_q && accept)
         begin
            hold_d = word_q;
            hold_v_d = 1'b1;
            ovr_d = hold_v_q && !in_ready;
         end
      end

      always_ff @(posedge clk_sys or negedge resetn)
      begin
         if (!resetn)
         begin
            sh_q <= '0;
            cnt_q <= '0;
            word_q <= '0;
            hold_q <= '0;
            idle_q <= '0;
            prev_q <= 1'b0;
            chk1_q <= 1'b0;
            chk2_q <= 1'b0;
            hold_v_q <= 1'b0;
            ovr_q <= 1'b0;
         end
         else
         begin
            sh_q <= sh_d;
            cnt_q <= cnt_d;
            word_q <= word_d;
            hold_q <= hold_d;
            idle_q <= idle_d;
            prev_q <= act;
            chk1_q <= chk1_d;
            chk2_q <= chk1_q;
            hold_v_q <= hold_v_d;
            ovr_q <= ovr_d;
         end
      end

      label_mem #(
         .DEPTH(arinc_pkg::LABEL_DEPTH),
         .AW(arinc_pkg::LABEL_BITS)
      ) u_lbl (
         .clk_sys(clk_sys),
         .resetn(resetn),
         .wr_en(we),
         .wr_addr(lbl_wr_label),
         .wr_data(lbl_wr_accept),
         .rd_addr(word_q[arinc_pkg::LABEL_BITS-1:0]),
         .rd_data(accept)
      );

      word_buf #(
         .WIDTH(W + 1),
         .DEPTH(2)
      ) u_buf (
         .clk_sys(clk_sys),
         .resetn(resetn),
         .in_valid(hold_v_q),
         .in_ready(in_ready),
         .in_data({~^hold_q, hold_q}),
         .out_valid(rx_valid[g]),
         .out_ready(rx_ready[g]),
         .out_data(out_data)
      );

      assign rx_word[g] = out_data[W-1:0];
      assign rx_parity_err[g] = out_data[W];
      assign rx_overrun[g] = ovr_q;

      property p_rx_parity;
         rx_valid[g] |-> rx_parity_err[g] == !(^rx_word[g]);
      endproperty
      a_rx_parity: assert property (p_rx_parity)
         else $error("parity flag does not match word");

      property p_rx_order;
         (start && cnt_q == '0) |=> sh_q[7] == $past(rx_hi[g]);
      endproperty
      a_rx_order: assert property (p_rx_order)
         else $error("first received bit not stored as label bit 8");

      property p_rx_len;
         (start && cnt_q == 6'(W-1)) |=> chk1_q && cnt_q == '0 ##2 chk2_q == 1'b0;
      endproperty
      a_rx_len: assert property (p_rx_len)
         else $error("word not closed at bit 32");

      property p_rx_gap;
         (idle_q == gap_lim && !start) |=> cnt_q == '0;
      endproperty
      a_rx_gap: assert property (p_rx_gap)
         else $error("gap did not reset word assembly");
   end
endmodule : arinc_word_codec
`default_nettype wire

// >>> line_partner.sv
// Line driver and line receiver model on the codec's serial side.
`timescale 1ns/1ps
`default_nettype none
module line_partner (
   input wire logic clk_sys,
   input wire logic tx_hi,
   input wire logic tx_lo,
   output logic rx_hi,
   output logic rx_lo,
   output logic [31:0] cap_word,
   output logic cap_valid,
   output int cap_per,
   output int cap_gap
);
   int n = 0;
   int cyc = 0;
   int null_cnt = 0;
   logic seen_q = 1'b0;

   initial
   begin
      rx_hi = 1'b0;
      rx_lo = 1'b0;
      cap_valid = 1'b0;
      cap_word = '0;
      cap_per = 0;
      cap_gap = 0;
   end

   // ****************************************************************
   // Receiver of the transmit line
   // ****************************************************************
   // A bit starts on a rising level of either wire; both wires low is Null.
   always @(posedge clk_sys)
   begin
      cap_valid <= 1'b0;
      cyc <= cyc + 1;
      null_cnt <= (tx_hi | tx_lo) ? 0 : null_cnt + 1;
      if ((tx_hi | tx_lo) && !seen_q)
      begin
         if (n == 0)
            cap_gap <= null_cnt;
         else
            cap_per <= cyc;
         cyc <= 1;
         cap_word[(n < 8) ? 7 - n : n] <= tx_hi;
         n <= (n == 31) ? 0 : n + 1;
         cap_valid <= (n == 31);
      end
      seen_q <= tx_hi | tx_lo;
   end

   // ****************************************************************
   // Driver of the receive line
   // ****************************************************************
   // Fewer than 32 bits gives a broken word for the gap recovery case.
   task automatic send_word(input logic [31:0] w, input int per,
                            input int nbits);
      for (int s = 0; s < nbits; s++)
      begin
         @(posedge clk_sys);
         #1;
         rx_hi = w[(s < 8) ? 7 - s : s];
         rx_lo = ~w[(s < 8) ? 7 - s : s];
         repeat (per / 2) @(posedge clk_sys);
         #1;
         rx_hi = 1'b0;
         rx_lo = 1'b0;
         repeat (per / 2 - 1) @(posedge clk_sys);
      end
      repeat (4 * per) @(posedge clk_sys);
   endtask : send_word
endmodule : line_partner
`default_nettype wire

// >>> tb_arinc_word_codec.sv
// Self-checking bench of the serial word codec with one channel each way.
`timescale 1ns/1ps
`default_nettype none
module tb_arinc_word_codec;
   localparam int HI = int'(arinc_pkg::CYC_HI);
   localparam int MID = int'(arinc_pkg::CYC_MID);
   localparam int LO = int'(arinc_pkg::CYC_LO);
   logic clk_sys = 1'b0;
   logic resetn = 1'b0;
   logic [1:0] tx_rate [1];
   logic [30:0] tx_word [1];
   logic tx_valid [1];
   logic tx_ready [1];
   logic tx_hi [1];
   logic tx_lo [1];
   logic [1:0] rx_rate [1];
   logic rx_hi [1];
   logic rx_lo [1];
   logic lbl_wr_en = 1'b0;
   logic [3:0] lbl_wr_chan = 4'h0;
   logic [7:0] lbl_wr_label = 8'h00;
   logic lbl_wr_accept = 1'b0;
   logic [31:0] rx_word [1];
   logic rx_parity_err [1];
   logic rx_valid [1];
   logic rx_ready [1];
   logic rx_overrun [1];
   logic p_hi;
   logic p_lo;
   logic [31:0] cap_word;
   logic cap_valid;
   int cap_per;
   int cap_gap;
   int error_cnt = 0;
   int compares = 0;
   int cycles = 0;
   int ntx = 0;
   int lastper = 0;
   int seed = 34780;
   int novr = 0;
   logic [31:0] txq [$];
   logic [32:0] rxq [$];
   int perq [$];

   assign rx_hi[0] = p_hi;
   assign rx_lo[0] = p_lo;

   always #25 clk_sys = ~clk_sys;

   arinc_word_codec #(.N_TX(1), .N_RX(1)) DUT (.clk_sys(clk_sys),
      .resetn(resetn), .tx_rate(tx_rate), .tx_word(tx_word),
      .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_hi(tx_hi),
      .tx_lo(tx_lo), .rx_rate(rx_rate), .rx_hi(rx_hi), .rx_lo(rx_lo),
      .lbl_wr_en(lbl_wr_en), .lbl_wr_chan(lbl_wr_chan),
      .lbl_wr_label(lbl_wr_label), .lbl_wr_accept(lbl_wr_accept),
      .rx_word(rx_word), .rx_parity_err(rx_parity_err),
      .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_overrun(rx_overrun));

   line_partner partner (.clk_sys(clk_sys), .tx_hi(tx_hi[0]),
      .tx_lo(tx_lo[0]), .rx_hi(p_hi), .rx_lo(p_lo), .cap_word(cap_word),
      .cap_valid(cap_valid), .cap_per(cap_per), .cap_gap(cap_gap));

   // ****************************************************************
   // Checking and closing
   // ****************************************************************
   task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                        input string what);
      compares++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("MISMATCH %0t %s: %h vs %h", $time, what, seen, exp);
      end
   endtask : check

   task automatic end_of_test;
      $display("Errors %0d, compares %0d", error_cnt, compares);
      if (error_cnt == 0 && compares > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : end_of_test

   always @(posedge clk_sys)
   begin
      logic [32:0] e;
      cycles = cycles + 1;
      if (resetn && rx_valid[0] === 1'b1 && rx_ready[0] === 1'b1)
      begin
         check(rxq.size() != 0, 1, "rx extra word");
         e = rxq.pop_front();
         check(rx_word[0], e[31:0], "rx word");
         check(rx_parity_err[0], e[32], "rx parity");
      end
      if (cap_valid === 1'b1)
      begin
         e = {1'b0, txq.pop_front()};
         check(cap_word, e[31:0], "tx word");
         check(cap_per, perq[0], "tx bit time");
         if (ntx > 0)
            check(cap_gap >= 4 * lastper, 1, "tx gap");
         lastper = perq.pop_front();
         ntx++;
      end
      if (resetn && rx_overrun[0] !== 1'b0)
      begin
         check(rx_overrun[0], 1, "overrun level");
         novr++;
      end
      // The line outputs are unknown until the first edge applies reset.
      if (resetn && tx_hi[0] !== 1'b0 && tx_lo[0] !== 1'b0)
         check(1, 0, "both levels");
      if (cycles == 95000)
      begin
         error_cnt++;
         end_of_test();
      end
   end

   // ****************************************************************
   // Stimulus
   // ****************************************************************
   // Valid stays high across words, so busy-time offers must be ignored.
   task automatic send_tx(input logic [1:0] r, input int per);
      logic [30:0] w;
      w = $random(seed);
      tx_word[0] = w;
      tx_rate[0] = r;
      tx_valid[0] = 1'b1;
      @(posedge clk_sys);
      while (tx_ready[0] !== 1'b1)
         @(posedge clk_sys);
      txq.push_back({~^w, w});
      perq.push_back(per);
      #1;
   endtask : send_tx

   task automatic rx_send(input logic [7:0] lbl, input logic bad,
                          input int per, input int nbits, input logic keep);
      logic [30:0] b;
      b = $random(seed);
      b[7:0] = lbl;
      if (keep)
         rxq.push_back({bad, (~^b) ^ bad, b});
      partner.send_word({(~^b) ^ bad, b}, per, nbits);
      #1;
   endtask : rx_send

   initial
   begin
      tx_rate[0] = arinc_pkg::RATE_SEL_HI;
      tx_word[0] = '0;
      tx_valid[0] = 1'b0;
      rx_rate[0] = arinc_pkg::RATE_SEL_HI;
      rx_ready[0] = 1'b0;
      repeat (5) @(posedge clk_sys);
      #1;
      resetn = 1'b1;
      check(tx_ready[0], 1, "ready after reset");
      check(rx_valid[0], 0, "valid after reset");
      lbl_wr_en = 1'b1;
      lbl_wr_label = 8'h3C;
      @(posedge clk_sys);
      #1;
      lbl_wr_en = 1'b0;
      fork
         begin
            send_tx(arinc_pkg::RATE_SEL_HI, HI);
            send_tx(arinc_pkg::RATE_SEL_HI, HI);
            send_tx(arinc_pkg::RATE_SEL_MID, MID);
            send_tx(arinc_pkg::RATE_SEL_HI, HI);
            send_tx(arinc_pkg::RATE_SEL_LO, LO);
            tx_valid[0] = 1'b0;
         end
         begin
            rx_send(8'h11, 1'b0, HI, 32, 1'b1);
            rx_send(8'h22, 1'b1, HI, 32, 1'b1);
            rx_send(8'h3C, 1'b0, HI, 32, 1'b0);
            check(rx_valid[0], 1, "held while stalled");
            // Buffer full: the held 8'h66 word is displaced, one overrun.
            rx_send(8'h66, 1'b0, HI, 32, 1'b0);
            rx_send(8'h77, 1'b0, HI, 32, 1'b1);
            rx_ready[0] = 1'b1;
            rx_send(8'h44, 1'b0, HI, 10, 1'b0);
            rx_rate[0] = arinc_pkg::RATE_SEL_MID;
            rx_send(8'h55, 1'b0, MID, 32, 1'b1);
         end
      join
      for (int i = 0; i < 40000 && txq.size() + rxq.size() > 0; i++)
         @(posedge clk_sys);
      check(txq.size() + rxq.size(), 0, "words outstanding");
      check(novr, 1, "overrun count");
      end_of_test();
   end
endmodule : tb_arinc_word_codec
`default_nettype wire
